// [design/coar_router.v]
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "coar_consts.vh"

module coar_router #(
	parameter HAS_HEATER_DETECT = 0,
	parameter HAS_CTRL_OUT2 = 0,
	parameter AUX_COUNT = 2,
	parameter PV_W = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [PV_W-1:0] process_value,
	input wire [PV_W-1:0] set_point,
	input wire heat_ctrl,
	input wire cool_ctrl,
	input wire [3:0] alarm_fn,
	input wire [3:0] work_bit,
	input wire heater_fault_alarm,
	input wire program_end,
	output wire [PV_W-1:0] manip_var,
	output wire action_direction_setting,
	output wire heat_cool_mode,
	output wire control_out1,
	output wire control_out2,
	output wire [3:0] aux_out,
	output wire [3:0] alarm_active
);

	reg rev_q;
	reg hc_q;
	reg [3:0] pat_q;
	reg [3:0] control_out1_select;
	reg [3:0] control_out2_select;
	reg [3:0] aux_out1_select;
	reg [3:0] aux_out2_select;
	reg [3:0] aux_out3_select;
	reg [3:0] aux_out4_select;
	reg [PV_W-1:0] mv_q;
	reg out1_q;
	reg out2_q;
	reg [3:0] aux_q;
	reg [31:0] prdata_q;

	wire wr_en;
	wire rd_setup;
	wire mapped;
	wire hc_new;
	wire [3:0] pat_new;
	wire [3:0] def_out2;
	wire [3:0] def_aux1;
	wire [3:0] def_aux2;
	wire [3:0] def_aux4;
	wire [3:0] hc_def_out2;
	wire [3:0] hc_def_aux2;
	wire [3:0] hc_def_aux4;
	wire [23:0] all_sel;
	wire [3:0] alarm_en;
	wire [15:0] fn_vec;
	wire [3:0] aux_mask;

	// apb slave: zero wait, read data captured in the setup cycle
	assign pready = 1'b1;
	assign mapped = (paddr == `COAR_OFF_CTRL) || (paddr == `COAR_OFF_CSEL) ||
		(paddr == `COAR_OFF_ASEL) || (paddr == `COAR_OFF_STAT) ||
		(paddr == `COAR_OFF_MV);
	assign pslverr = psel & penable & ~mapped;
	assign wr_en = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign prdata = prdata_q;

	assign hc_new = pwdata[`COAR_CTRL_HC_BIT];
	assign pat_new = pwdata[`COAR_CTRL_PAT_LSB +: `COAR_CTRL_PAT_W];

	// standard-mode defaults
	assign def_out2 = `COAR_FN_NONE;
	assign def_aux1 = HAS_HEATER_DETECT ? `COAR_FN_HTR : `COAR_FN_ALM1;
	assign def_aux2 = `COAR_FN_ALM2;
	assign def_aux4 = `COAR_FN_ALM4;

	// heating/cooling defaults: cooling lands where the fitted outputs allow
	assign hc_def_out2 = HAS_CTRL_OUT2 ? `COAR_FN_COOL : `COAR_FN_NONE;
	assign hc_def_aux2 = (AUX_COUNT == 2) ? `COAR_FN_COOL : `COAR_FN_ALM2;
	assign hc_def_aux4 = (AUX_COUNT == 4 && !HAS_CTRL_OUT2) ?
		`COAR_FN_COOL : `COAR_FN_ALM4;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rev_q <= `COAR_RST_REV;
			hc_q <= `COAR_RST_HC;
			pat_q <= `COAR_RST_PAT;
			control_out1_select <= `COAR_FN_HEAT;
			control_out2_select <= `COAR_FN_NONE;
			aux_out1_select <= HAS_HEATER_DETECT ? `COAR_FN_HTR : `COAR_FN_ALM1;
			aux_out2_select <= `COAR_FN_ALM2;
			aux_out3_select <= `COAR_FN_ALM3;
			aux_out4_select <= `COAR_FN_ALM4;
		end else if (wr_en) begin
			case (paddr)
			`COAR_OFF_CTRL: begin
				// direction write leaves the routing untouched
				rev_q <= pwdata[`COAR_CTRL_REV_BIT];
				hc_q <= hc_new;
				pat_q <= pat_new;
				if (hc_new != hc_q) begin
					// mode change reloads every assignment
					control_out1_select <= `COAR_FN_HEAT;
					control_out2_select <= hc_new ? hc_def_out2 : def_out2;
					aux_out2_select <= hc_new ? hc_def_aux2 : def_aux2;
					aux_out3_select <= `COAR_FN_ALM3;
					aux_out4_select <= hc_new ? hc_def_aux4 : def_aux4;
				end
				// pattern switched on overrides the aux1 reload
				if (pat_new != `COAR_RST_PAT && pat_new != pat_q) begin
					aux_out1_select <= `COAR_FN_PEND;
				end else if (hc_new != hc_q) begin
					aux_out1_select <= def_aux1;
				end
			end
			`COAR_OFF_CSEL: begin
				control_out1_select <= pwdata[`COAR_CSEL_OUT1_LSB +: `COAR_SEL_W];
				control_out2_select <= pwdata[`COAR_CSEL_OUT2_LSB +: `COAR_SEL_W];
			end
			`COAR_OFF_ASEL: begin
				aux_out1_select <= pwdata[3:0];
				aux_out2_select <= pwdata[7:4];
				aux_out3_select <= pwdata[11:8];
				aux_out4_select <= pwdata[15:12];
			end
			default: begin
			end
			endcase
		end
	end

	// only fitted outputs take part in enabling alarms
	assign aux_mask = (AUX_COUNT >= 4) ? 4'hF : 4'h3;
	assign all_sel = {
		aux_mask[3] ? aux_out4_select : `COAR_FN_NONE,
		aux_mask[2] ? aux_out3_select : `COAR_FN_NONE,
		aux_out2_select,
		aux_out1_select,
		HAS_CTRL_OUT2 ? control_out2_select : `COAR_FN_NONE,
		control_out1_select};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_alen
			wire [5:0] hit;
			genvar gj;
			for (gj = 0; gj < 6; gj = gj + 1) begin : g_sel
				wire [3:0] s;
				assign s = all_sel[gj*4 +: 4];
				assign hit[gj] = (s == `COAR_FN_ALM1 + gi) ||
					(s >= `COAR_FN_WB1 && s <= `COAR_FN_WB4);
			end
			assign alarm_en[gi] = |hit;
		end
	endgenerate

	assign alarm_active = alarm_en;

	// function vector indexed by select code; unused codes route low
	assign fn_vec = {3'b000, work_bit, program_end, heater_fault_alarm,
		alarm_fn & alarm_en, cool_ctrl, heat_ctrl, 1'b0};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out1_q <= 1'b0;
			out2_q <= 1'b0;
			aux_q <= 4'h0;
		end else begin
			out1_q <= fn_vec[control_out1_select];
			out2_q <= HAS_CTRL_OUT2 ? fn_vec[control_out2_select] : 1'b0;
			aux_q[0] <= fn_vec[aux_out1_select];
			aux_q[1] <= fn_vec[aux_out2_select];
			aux_q[2] <= aux_mask[2] & fn_vec[aux_out3_select];
			aux_q[3] <= aux_mask[3] & fn_vec[aux_out4_select];
		end
	end

	assign control_out1 = out1_q;
	assign control_out2 = out2_q;
	assign aux_out = aux_q;

	// manipulated variable follows the deviation in the chosen sense
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mv_q <= {PV_W{1'b0}};
		end else if (rev_q) begin
			mv_q <= set_point - process_value;
		end else begin
			mv_q <= process_value - set_point;
		end
	end

	assign manip_var = mv_q;
	assign action_direction_setting = rev_q;
	assign heat_cool_mode = hc_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (paddr)
			`COAR_OFF_CTRL: prdata_q <= {24'h00_0000, pat_q, 2'b00, hc_q, rev_q};
			`COAR_OFF_CSEL: prdata_q <= {24'h00_0000, control_out2_select,
				control_out1_select};
			`COAR_OFF_ASEL: prdata_q <= {16'h0000, aux_out4_select, aux_out3_select,
				aux_out2_select, aux_out1_select};
			`COAR_OFF_STAT: prdata_q <= {20'h0_0000, alarm_en, 2'b00, aux_q,
				out2_q, out1_q};
			`COAR_OFF_MV: prdata_q <= {{(32-PV_W){1'b0}}, mv_q};
			default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

endmodule // coar_router

// [design/coar_consts.vh]
`ifndef COAR_CONSTS_VH
`define COAR_CONSTS_VH

// register byte offsets
`define COAR_OFF_CTRL 12'h000
`define COAR_OFF_CSEL 12'h004
`define COAR_OFF_ASEL 12'h008
`define COAR_OFF_STAT 12'h00C
`define COAR_OFF_MV 12'h010

// control register fields
`define COAR_CTRL_REV_BIT 0
`define COAR_CTRL_HC_BIT 1
`define COAR_CTRL_PAT_LSB 4
`define COAR_CTRL_PAT_W 4

// select register fields: four bits per output
`define COAR_SEL_W 4
`define COAR_CSEL_OUT1_LSB 0
`define COAR_CSEL_OUT2_LSB 4

// status register fields
`define COAR_STAT_OUT_LSB 0
`define COAR_STAT_ALEN_LSB 8

// reset values
`define COAR_RST_REV 1'b1
`define COAR_RST_HC 1'b0
`define COAR_RST_PAT 4'h0

// function codes for an output select
`define COAR_FN_NONE 4'h0
`define COAR_FN_HEAT 4'h1
`define COAR_FN_COOL 4'h2
`define COAR_FN_ALM1 4'h3
`define COAR_FN_ALM2 4'h4
`define COAR_FN_ALM3 4'h5
`define COAR_FN_ALM4 4'h6
`define COAR_FN_HTR 4'h7
`define COAR_FN_PEND 4'h8
`define COAR_FN_WB1 4'h9
`define COAR_FN_WB4 4'hC

`endif

// [verif/coar_chk.sv]
`timescale 1ns/1ps
module coar_chk #(parameter HAS_HEATER_DETECT = 0, parameter HAS_CTRL_OUT2 = 0,
	parameter AUX_COUNT = 2) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire action_direction_setting,
	input wire heat_cool_mode,
	input wire control_out2,
	input wire [3:0] aux_out,
	input wire [3:0] alarm_active
);
	localparam logic [3:0] ALM_RST = (AUX_COUNT == 4 ? 4'hF : 4'h3) & ~{3'h0, HAS_HEATER_DETECT != 0};
	wire wr_acc = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_rst_dir: assert property ($rose(presetn) |-> action_direction_setting)
		else $error("direction not reverse after reset");
	chk_rst_mode: assert property ($rose(presetn) |-> !heat_cool_mode)
		else $error("mode not standard after reset");
	chk_rst_alarm: assert property ($rose(presetn) |-> alarm_active == ALM_RST)
		else $error("alarm enables wrong after reset");
	chk_unfit_low: assert property ((HAS_CTRL_OUT2 != 0 || !control_out2) &&
		(AUX_COUNT == 4 || aux_out[3:2] == 2'b00)) else $error("unfitted output driven");
	chk_alarm_write: assert property ($changed(alarm_active) |-> $past(wr_acc))
		else $error("alarm enables moved without a write");
	chk_mode_write: assert property ($changed(heat_cool_mode) |-> $past(wr_acc))
		else $error("mode moved without a write");
	chk_dir_write: assert property (!wr_acc |=> $stable(action_direction_setting))
		else $error("direction moved without a write");
	chk_dir_keep: assert property ($changed(action_direction_setting) &&
		$stable(heat_cool_mode) |-> $stable(alarm_active)) else $error("direction moved selects");
	cover property ($changed(heat_cool_mode));
	cover property ($changed(action_direction_setting));
	cover property ($changed(alarm_active));
endmodule // coar_chk

bind coar_router coar_chk #(.HAS_HEATER_DETECT(HAS_HEATER_DETECT), .HAS_CTRL_OUT2(HAS_CTRL_OUT2),
	.AUX_COUNT(AUX_COUNT)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .action_direction_setting(action_direction_setting),
	.heat_cool_mode(heat_cool_mode), .control_out2(control_out2), .aux_out(aux_out),
	.alarm_active(alarm_active));

// [verif/coar_load.sv]
`timescale 1ns/1ps
module coar_load (
	input wire pclk,
	input wire control_out1,
	input wire control_out2,
	input wire [3:0] aux_out,
	output logic [5:0] load_q
);
	// loads follow their drive one clock later, like a contactor
	always @(posedge pclk) begin
		load_q <= {aux_out, control_out2, control_out1};
	end
endmodule // coar_load

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "coar_consts.vh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, heat, cool, htr, pend, o1, o2;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, cs, as, ctl, r;
	logic [31:0] seed = 32'h0000_0051;
	logic [15:0] pv, sp;
	logic [3:0] alm, wb, aux;
	logic [5:0] ld;
	logic [32:0] expq[$];
	int fail_count, checks;
	coar_router #(.AUX_COUNT(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .process_value(pv), .set_point(sp), .heat_ctrl(heat),
		.cool_ctrl(cool), .alarm_fn(alm), .work_bit(wb), .heater_fault_alarm(htr),
		.program_end(pend), .manip_var(), .action_direction_setting(), .heat_cool_mode(),
		.control_out1(o1), .control_out2(o2), .aux_out(aux), .alarm_active());
	coar_load load_u (.pclk(pclk), .control_out1(o1), .control_out2(o2), .aux_out(aux), .load_q(ld));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic fnv(input logic [3:0] c);
		if (c == `COAR_FN_HEAT) return heat;
		if (c == `COAR_FN_COOL) return cool;
		if (c >= `COAR_FN_ALM1 && c <= `COAR_FN_ALM4) return alm[c - 4'h3];
		if (c == `COAR_FN_HTR) return htr;
		if (c == `COAR_FN_PEND) return pend;
		if (c >= `COAR_FN_WB1 && c <= `COAR_FN_WB4) return wb[c - 4'h9];
		return 1'b0;
	endfunction
	function automatic logic [31:0] stat_exp();
		logic [3:0] en, a, c;
		en = 4'h0;
		for (int k = 0; k < 5; k++) begin
			c = (k == 0) ? cs[3:0] : as[4*k-4 +: 4];
			if (c >= `COAR_FN_ALM1 && c <= `COAR_FN_ALM4) en[c - 4'h3] = 1'b1;
			if (c >= `COAR_FN_WB1 && c <= `COAR_FN_WB4) en = 4'hF;
			if (k > 0) a[k-1] = fnv(c);
		end
		return {20'h0_0000, en, 2'b00, a, 1'b0, fnv(cs[3:0])};
	endfunction
	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			fail_count++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
		expq.push_back({e, d});
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task automatic stir();
		logic [31:0] q;
		r = rnd();
		q = rnd();
		@(posedge pclk);
		{heat, cool, htr, pend, alm, wb} <= r[11:0];
		pv <= r[31:16];
		sp <= q[15:0];
		// outputs register one edge later, the loads one more
		repeat (3) @(posedge pclk);
	endtask
	task automatic cmp_load(input logic [5:0] e);
		checks++;
		if (ld !== e) begin
			fail_count++;
			$display("[ERR] load_q exp %h seen %h", e, ld);
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready) cmp({pslverr, prdata});
	end
	task automatic cmp(input logic [32:0] seen);
		logic [32:0] e;
		e = expq.pop_front();
		checks++;
		if (seen !== e) begin
			fail_count++;
			$display("[ERR] pslverr_prdata exp %h seen %h", e, seen);
		end
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{heat, cool, htr, pend, alm, wb, pv, sp} = '0;
		fail_count = 0;
		checks = 0;
		{ctl, cs, as} = {32'h0000_0001, 32'h0000_0001, 32'h0000_6543};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`COAR_OFF_CTRL, ctl);
		rd(`COAR_OFF_CSEL, cs);
		rd(`COAR_OFF_ASEL, as);
		rd(`COAR_OFF_STAT, stat_exp());
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			cs = {24'h00_0000, r[23:16]};
			as = {16'h0000, r[15:4], i[3:0]};
			bus(1'b1, `COAR_OFF_CSEL, cs);
			bus(1'b1, `COAR_OFF_ASEL, as);
			stir();
			r = stat_exp();
			cmp_load(r[5:0]);
			rd(`COAR_OFF_STAT, stat_exp());
		end
		{ctl, cs, as} = {32'h0000_0003, 32'h0000_0001, 32'h0000_2543};
		bus(1'b1, `COAR_OFF_CTRL, ctl);
		rd(`COAR_OFF_CSEL, cs);
		rd(`COAR_OFF_ASEL, as);
		stir();
		r = stat_exp();
		cmp_load(r[5:0]);
		rd(`COAR_OFF_STAT, stat_exp());
		for (int i = 0; i < 2; i++) begin
			ctl[0] = i[0];
			bus(1'b1, `COAR_OFF_CTRL, ctl);
			stir();
			rd(`COAR_OFF_MV, {16'h0000, i ? sp - pv : pv - sp});
			rd(`COAR_OFF_CSEL, cs);
		end
		{ctl, as} = {32'h0000_0001, 32'h0000_6543};
		bus(1'b1, `COAR_OFF_CTRL, ctl);
		rd(`COAR_OFF_ASEL, as);
		{ctl, as} = {32'h0000_0051, 32'h0000_6548};
		bus(1'b1, `COAR_OFF_CTRL, ctl);
		rd(`COAR_OFF_ASEL, as);
		rd(12'h020, 32'h0000_0000, 1'b1);
		repeat (2) @(posedge pclk);
		close_out();
	end
endmodule // testbench
